// file: rtl/rtcs_core.sv
// Sub-second counter, clock shift, timestamp capture and smooth calibration.
// Assumes the calendar, its shadow copies and the divider setting live outside
// and run on pclk, which is also the kernel clock of the calendar.
// Notes on behaviour
// RL1 - Sub-second register shows live prescaler counter
// RL2 - Count above divider only after shift
// RL3 - Add-second bit advances calendar one second
// RL4 - Fraction write adds to counter; ignored while pending
// RL5 - Shift control fields always read zero
// RL6 - Fraction write clears sync flag until shifted
// RL7 - Software never adds second with zero fraction
// RL8 - Stamp time holds BCD time fields
// RL9 - Stamp date holds BCD date fields
// RL10 - Weekday code zero is never captured
// RL11 - Stamp sub-second holds counter at event
// RL12 - Captured count above divider only after shift
// RL13 - Insert bit adds pulse every 2^11
// RL14 - Net adjustment is 512*insert minus mask
// RL15 - Eight-second period zeroes two mask bits
// RL16 - Sixteen-second period zeroes mask bit zero
// RL17 - Mask count suppresses pulses per window
// RL18 - No period bit means full window
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module rtcs_core
  import rtcs_pkg::*;
#(
  parameter int CYCLE_LOG2  = CAL_CYCLE_LOG2,
  parameter int INSERT_BITS = INSERT_LOG2
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [APB_ADDR_W-1:0]  paddr,
  input  wire logic [APB_DATA_W-1:0]  pwdata,
  output logic      [APB_DATA_W-1:0]  prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [FRACTION_MSB:0]  sync_prescale_divider,
  input  wire logic                   stamp_event,
  input  wire logic [31:0]            live_time,
  input  wire logic [31:0]            live_date,
  input  wire logic                   shadow_update,
  output logic      [SUBSEC_MSB:0]    sync_prescale_count,
  output logic                        second_tick,
  output logic                        add_second_pulse,
  output logic                        shift_pending_flag,
  output logic                        shadow_sync_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Cycle splits into insert slots and nine mask-slot bits
  if (CYCLE_LOG2 != INSERT_BITS + MASK_SLOT_BITS) begin : g_bad_cfg
    $error("rtcs_core: cycle length must be insert length plus nine bits");
  end

  // Inserts sit mid-slot, so a slot needs two bit positions at least
  if (INSERT_BITS < 2) begin : g_bad_insert
    $error("rtcs_core: insert slot needs at least two bits");
  end

  // Mask count and slot index are compared bit for bit
  if (MASK_COUNT_MSB + 1 != MASK_SLOT_BITS) begin : g_bad_mask
    $error("rtcs_core: mask count width must match the mask slot width");
  end

  // Room for a divider-wide fraction on top of the count
  if (SUBSEC_MSB != FRACTION_MSB + 1) begin : g_bad_count
    $error("rtcs_core: counter must be one bit wider than the divider");
  end

  // Offsets are eight-bit byte addresses of whole words
  if (APB_ADDR_W != 8 || APB_DATA_W != 32) begin : g_bad_bus
    $error("rtcs_core: bus must have 8 address and 32 data bits");
  end

  // Weekday field is a three-bit code
  if (WEEKDAY_MSB - WEEKDAY_LSB != 2) begin : g_bad_weekday
    $error("rtcs_core: weekday field must be three bits wide");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic        setup_phase;
  logic        wr_commit;
  logic        hit_subsec;
  logic        hit_shift;
  logic        hit_stime;
  logic        hit_sdate;
  logic        hit_sss;
  logic        hit_cal;
  logic        hit_any;

  assign setup_phase = psel & ~penable;
  assign wr_commit   = psel & penable & pready & pwrite;
  assign hit_subsec  = (paddr == OFS_SUBSECOND);
  assign hit_shift   = (paddr == OFS_SHIFT_CTRL);
  assign hit_stime   = (paddr == OFS_STAMP_TIME);
  assign hit_sdate   = (paddr == OFS_STAMP_DATE);
  assign hit_sss     = (paddr == OFS_STAMP_SUBSEC);
  assign hit_cal     = (paddr == OFS_SMOOTH_CAL);
  assign hit_any     = hit_subsec | hit_shift | hit_stime | hit_sdate | hit_sss | hit_cal;

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic                    cal_insert;
  logic                    cal_eight;
  logic                    cal_sixteen;
  logic [MASK_COUNT_MSB:0] cal_mask;
  logic [31:0]             stamp_time;
  logic [31:0]             stamp_date;
  logic [SUBSEC_MSB:0]     stamp_subsec;
  logic [FRACTION_MSB:0]   shift_fraction;
  logic                    shift_add;
  rtcs_shift_state_t       shift_state;
  rtcs_shift_state_t       next_shift_state;
  logic                    shift_write;
  logic                    shift_apply;

  // A write during a pending shift is dropped whole, both fields.
  assign shift_write = wr_commit & hit_shift & (shift_state == RTCS_SHIFT_IDLE); // RL4
  assign shift_apply = (shift_state == RTCS_SHIFT_APPLY);

  ////////////////////////////////////////////////////////////////////////////
  // Calibration register

  logic [MASK_COUNT_MSB:0] wr_mask;
  logic                    wr_eight;
  logic                    wr_sixteen;

  always_comb begin
    wr_eight   = pwdata[EIGHT_SEC_BIT];
    // Eight-second selection takes priority if software sets both
    wr_sixteen = pwdata[SIXTEEN_SEC_BIT] & ~wr_eight; // RL16
    wr_mask    = pwdata[MASK_COUNT_MSB:0];
    if (wr_eight) begin
      wr_mask[1:0] = 2'h0; // RL15
    end else if (wr_sixteen) begin
      wr_mask[0] = 1'b0; // RL16
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_insert  <= 1'b0;
      cal_eight   <= 1'b0;
      cal_sixteen <= 1'b0;
      cal_mask    <= RST_MASK_COUNT;
    end else if (wr_commit && hit_cal) begin
      cal_insert  <= pwdata[INSERT_BIT];
      cal_eight   <= wr_eight;
      cal_sixteen <= wr_sixteen;
      cal_mask    <= wr_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration window and pulse steering

  logic [CYCLE_LOG2-1:0]     cal_cnt;
  logic                      last_eight;
  logic                      last_sixteen;
  logic                      last_full;
  logic                      win_last;
  logic [MASK_SLOT_BITS-1:0] mask_slot;
  logic [MASK_COUNT_MSB:0]   eff_mask;
  logic                      slot_start;
  logic                      slot_mid;
  logic                      pulse_masked;
  logic                      pulse_inserted;
  logic [1:0]                step;

  assign last_eight   = &cal_cnt[CYCLE_LOG2-3:0];
  assign last_sixteen = last_eight & cal_cnt[CYCLE_LOG2-2];
  assign last_full    = last_sixteen & cal_cnt[CYCLE_LOG2-1];

  always_comb begin
    if (cal_eight) begin
      win_last = last_eight; // RL15
      eff_mask = cal_mask >> 2;
    end else if (cal_sixteen) begin
      win_last = last_sixteen; // RL16
      eff_mask = cal_mask >> 1;
    end else begin
      win_last = last_full; // RL18
      eff_mask = cal_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_cnt <= '0;
    end else if (win_last) begin
      cal_cnt <= '0;
    end else begin
      cal_cnt <= cal_cnt + 1'b1;
    end
  end

  // Masks and inserts sit half a slot apart so they never collide.
  assign mask_slot      = cal_cnt[CYCLE_LOG2-1:INSERT_BITS];
  assign slot_start     = (cal_cnt[INSERT_BITS-1:0] == '0);
  assign slot_mid       = (cal_cnt[INSERT_BITS-1:0] == {1'b1, {(INSERT_BITS-1){1'b0}}});
  assign pulse_masked   = slot_start & (mask_slot < eff_mask); // RL17
  assign pulse_inserted = slot_mid & cal_insert; // RL13
  // Per window: inserts count up once per slot, masks down per slot below the count
  assign step = pulse_masked ? STEP_MASKED :
                pulse_inserted ? STEP_INSERTED : STEP_NORMAL; // RL14

  ////////////////////////////////////////////////////////////////////////////
  // Synchronous prescaler counter

  logic [SUBSEC_MSB+1:0] diff;
  logic [SUBSEC_MSB+1:0] wrapped;
  logic                  wrap;
  logic [SUBSEC_MSB:0]   next_count;

  always_comb begin
    diff    = {1'b0, sync_prescale_count} - {{SUBSEC_MSB{1'b0}}, step};
    wrap    = diff[SUBSEC_MSB+1];
    wrapped = diff;
    if (wrap) begin
      wrapped = diff + {2'b00, sync_prescale_divider} + 17'h00001;
    end
    next_count = wrapped[SUBSEC_MSB:0];
    if (shift_apply) begin
      // Can push the count above the divider, holding time back
      next_count = wrapped[SUBSEC_MSB:0] + {1'b0, shift_fraction}; // RL4 RL2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_prescale_count <= RST_SUBSECOND;
      second_tick         <= 1'b0;
    end else begin
      sync_prescale_count <= next_count; // RL1
      second_tick         <= wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift sequencer

  always_comb begin
    case (shift_state)
      RTCS_SHIFT_IDLE: begin
        next_shift_state = shift_write ? RTCS_SHIFT_APPLY : RTCS_SHIFT_IDLE;
      end
      RTCS_SHIFT_APPLY: begin
        next_shift_state = RTCS_SHIFT_IDLE;
      end
      default: begin
        next_shift_state = RTCS_SHIFT_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_state        <= RTCS_SHIFT_IDLE;
      shift_pending_flag <= 1'b0;
    end else begin
      shift_state        <= next_shift_state;
      shift_pending_flag <= (next_shift_state == RTCS_SHIFT_APPLY);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_fraction <= '0;
      shift_add      <= 1'b0;
    end else if (shift_write) begin
      shift_fraction <= pwdata[FRACTION_MSB:0]; // RL4
      shift_add      <= pwdata[ADD_SECOND_BIT]; // RL7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      add_second_pulse <= 1'b0;
    end else begin
      add_second_pulse <= shift_apply & shift_add; // RL3
    end
  end

  // Clear beats a coinciding update: that update still carries pre-shift time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_sync_flag <= 1'b0;
    end else if (shift_write) begin
      shadow_sync_flag <= 1'b0; // RL6
    end else if (shadow_update && !shift_apply) begin
      shadow_sync_flag <= 1'b1; // RL6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timestamp capture

  logic [2:0] live_weekday;

  assign live_weekday = live_date[WEEKDAY_MSB:WEEKDAY_LSB];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stamp_time   <= RST_STAMP_TIME;
      stamp_subsec <= RST_STAMP_SUBSEC;
    end else if (stamp_event) begin
      stamp_time   <= live_time & STAMP_TIME_MASK; // RL8
      // May exceed the divider after a shift; software adjusts
      stamp_subsec <= sync_prescale_count; // RL11 RL12
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stamp_date <= RST_STAMP_DATE;
    end else if (stamp_event) begin
      stamp_date <= live_date & STAMP_DATE_MASK; // RL9
      if (live_weekday == WEEKDAY_FORBIDDEN) begin
        // Keep the last valid weekday rather than store a forbidden code
        stamp_date[WEEKDAY_MSB:WEEKDAY_LSB] <= stamp_date[WEEKDAY_MSB:WEEKDAY_LSB]; // RL10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and bus answer

  logic [31:0] read_word;

  always_comb begin
    read_word = 32'h00000000;
    if (hit_subsec) begin
      read_word = {16'h0000, sync_prescale_count}; // RL1
    end else if (hit_shift) begin
      read_word = 32'h00000000; // RL5
    end else if (hit_stime) begin
      read_word = stamp_time; // RL8
    end else if (hit_sdate) begin
      read_word = stamp_date; // RL9
    end else if (hit_sss) begin
      read_word = {16'h0000, stamp_subsec}; // RL11
    end else if (hit_cal) begin
      read_word = {16'h0000, cal_insert, cal_eight, cal_sixteen, 4'h0, cal_mask};
    end
  end

  // Zero wait states: answer sampled in the setup cycle, ready for one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~hit_any;
      if (setup_phase && !pwrite) begin
        prdata <= read_word;
      end
    end
  end

endmodule

`default_nettype wire

// file: shared/rtcs_pkg.sv
// Package for the sub-second, shift, timestamp and smooth calibration block.
// Assumes one clock: the register bus clock also serves as the kernel clock.
package rtcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus widths and register byte offsets
  localparam int          APB_ADDR_W       = 8;
  localparam int          APB_DATA_W       = 32;
  localparam logic [7:0]  OFS_SUBSECOND    = 8'h28;
  localparam logic [7:0]  OFS_SHIFT_CTRL   = 8'h2C;
  localparam logic [7:0]  OFS_STAMP_TIME   = 8'h30;
  localparam logic [7:0]  OFS_STAMP_DATE   = 8'h34;
  localparam logic [7:0]  OFS_STAMP_SUBSEC = 8'h38;
  localparam logic [7:0]  OFS_SMOOTH_CAL   = 8'h3C;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] RST_STAMP_TIME   = 32'h00000000;
  localparam logic [31:0] RST_STAMP_DATE   = 32'h00000000;
  localparam logic [15:0] RST_STAMP_SUBSEC = 16'h0000;
  localparam logic [15:0] RST_SUBSECOND    = 16'h0000;
  localparam logic [8:0]  RST_MASK_COUNT   = 9'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int          SUBSEC_MSB       = 15;
  localparam int          ADD_SECOND_BIT   = 31;
  localparam int          FRACTION_MSB     = 14;
  localparam int          INSERT_BIT       = 15;
  localparam int          EIGHT_SEC_BIT    = 14;
  localparam int          SIXTEEN_SEC_BIT  = 13;
  localparam int          MASK_COUNT_MSB   = 8;
  localparam int          WEEKDAY_LSB      = 13;
  localparam int          WEEKDAY_MSB      = 15;
  // afternoon 22, hr tens 21:20, hr units 19:16, minute 14:8, second 6:0
  localparam logic [31:0] STAMP_TIME_MASK  = 32'h007F7F7F;
  // year 23:16, weekday 15:13, month 12:8, day of month 5:0
  localparam logic [31:0] STAMP_DATE_MASK  = 32'h00FFFF3F;
  localparam logic [2:0]  WEEKDAY_FORBIDDEN = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Calibration timing in kernel pulses
  localparam int          CAL_CYCLE_LOG2   = 20;
  localparam int          INSERT_LOG2      = 11;
  localparam int          MASK_SLOT_BITS   = 9;
  localparam logic [1:0]  STEP_MASKED      = 2'h0;
  localparam logic [1:0]  STEP_NORMAL      = 2'h1;
  localparam logic [1:0]  STEP_INSERTED    = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Shift sequencer
  typedef enum logic [1:0] {
    RTCS_SHIFT_IDLE  = 2'b01,
    RTCS_SHIFT_APPLY = 2'b10
  } rtcs_shift_state_t;

endpackage

// file: dv/rtcs_core_chk.sv
// Port checker for the sub-second, shift and shadow sync flag ports of the block.
// Assumes a steady divider and calibration off while a shift is applied.
`timescale 1ns/1ps
`default_nettype none
module rtcs_core_chk
  import rtcs_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [14:0] sync_prescale_divider,
  input wire logic        shadow_update,
  input wire logic [15:0] sync_prescale_count,
  input wire logic        add_second_pulse,
  input wire logic        shift_pending_flag,
  input wire logic        shadow_sync_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  logic [14:0] frac_q;
  logic        shifted_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frac_q    <= 15'h0000;
      shifted_q <= 1'b0;
    end else begin
      if (psel && penable && pwrite && pready && paddr == OFS_SHIFT_CTRL) begin
        frac_q <= pwdata[14:0];
      end
      if (shift_pending_flag) begin
        shifted_q <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  sequence s_read(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence s_shift_wr;
    psel && penable && pwrite && pready && paddr == OFS_SHIFT_CTRL;
  endsequence
  property p_subsec_read;
    s_read(OFS_SUBSECOND) |=> prdata == {16'h0000, $past(sync_prescale_count)};
  endproperty
  a_subsec_read: assert property (p_subsec_read) else $error("subsecond read wrong");
  property p_count_bound;
    !shifted_q |-> sync_prescale_count <= {1'b0, sync_prescale_divider};
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("count above divider");
  property p_add_second;
    s_shift_wr ##0 pwdata[ADD_SECOND_BIT] |=> shift_pending_flag ##1 add_second_pulse;
  endproperty
  a_add_second: assert property (p_add_second) else $error("no add second pulse");
  property p_add_cause;
    add_second_pulse |-> $past(shift_pending_flag);
  endproperty
  a_add_cause: assert property (p_add_cause) else $error("stray add second");
  property p_fraction_add;
    shift_pending_flag |=> sync_prescale_count == (($past(sync_prescale_count) == 16'h0000) ?
      {1'b0, $past(sync_prescale_divider)} : $past(sync_prescale_count) - 16'h0001) + frac_q;
  endproperty
  a_fraction_add: assert property (p_fraction_add) else $error("fraction not added");
  property p_shift_reads_zero;
    s_read(OFS_SHIFT_CTRL) |=> prdata == 32'h00000000;
  endproperty
  a_shift_reads_zero: assert property (p_shift_reads_zero) else $error("shift read");
  property p_sync_clear;
    s_shift_wr |=> shift_pending_flag && !shadow_sync_flag;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("sync flag kept");
  property p_sync_rise;
    $rose(shadow_sync_flag) |-> $past(shadow_update);
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("sync flag uncaused");
endmodule

bind rtcs_core rtcs_core_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .sync_prescale_divider(sync_prescale_divider), .shadow_update(shadow_update),
  .sync_prescale_count(sync_prescale_count), .add_second_pulse(add_second_pulse),
  .shift_pending_flag(shift_pending_flag), .shadow_sync_flag(shadow_sync_flag)
);
`default_nettype wire

// file: dv/tb_rtcs_core.sv
// Self-checking bench for the sub-second, shift, stamp and calibration block.
// Assumes short calibration windows: 2^11 cycles, insert every 4.
`timescale 1ns/1ps
`default_nettype none
module tb_rtcs_core import rtcs_pkg::*;;
  localparam logic [14:0] DIV = 15'h03FF;
  logic        pclk, presetn, psel, penable, pwrite, stamp_event, shadow_update;
  logic        pready, pslverr, tick, add_p, pend, sync, err;
  logic [7:0]  paddr;
  logic [15:0] cnt;
  logic [31:0] pwdata, prdata, live_time, live_date, rd;
  int          error_cnt, checks;

  rtcs_core #(.CYCLE_LOG2(11), .INSERT_BITS(2)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_prescale_divider(DIV), .stamp_event(stamp_event), .live_time(live_time),
    .live_date(live_date), .shadow_update(shadow_update), .sync_prescale_count(cnt),
    .second_tick(tick), .add_second_pulse(add_p), .shift_pending_flag(pend),
    .shadow_sync_flag(sync)
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No own limit: a slave that never answers is caught by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h00000000);
    chk("rdata", rd, exp);
    chk("slverr", 32'(err), 32'(e));
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] ofs[5];
    ofs = '{OFS_SHIFT_CTRL, OFS_STAMP_TIME, OFS_STAMP_DATE, OFS_STAMP_SUBSEC, OFS_SMOOTH_CAL};
    foreach (ofs[i]) rd_chk(ofs[i], 32'h00000000, 1'b0);
    apb(1'b1, OFS_STAMP_TIME, 32'hFFFFFFFF);
    rd_chk(OFS_STAMP_TIME, 32'h00000000, 1'b0);
    rd_chk(8'h40, 32'h00000000, 1'b1);
    apb(1'b0, OFS_SUBSECOND, 32'h00000000);
    chk("subsec_hi", {16'h0000, rd[31:16]}, 32'h00000000);
    $display("test regs done");
  endtask

  task automatic stamp(input logic [31:0] t, input logic [31:0] d, output logic [15:0] s);
    @(posedge pclk);
    live_time <= t;
    live_date <= d;
    stamp_event <= 1'b1;
    @(negedge pclk);
    s = cnt;
    @(posedge pclk);
    stamp_event <= 1'b0;
  endtask

  task automatic t_stamp;
    logic [15:0] s;
    stamp(32'hFFD2B9D9, 32'hFF2572F1, s);
    rd_chk(OFS_STAMP_TIME, 32'h00523959, 1'b0);
    rd_chk(OFS_STAMP_DATE, 32'h00257231, 1'b0);
    rd_chk(OFS_STAMP_SUBSEC, {16'h0000, s}, 1'b0);
    stamp(32'h00000000, 32'h00010101, s);
    rd_chk(OFS_STAMP_DATE, 32'h00016101, 1'b0);
    $display("test stamp done");
  endtask

  // Progress summed over one full window, after one window to settle
  task automatic cal_case(input logic [31:0] w, input logic [31:0] rb, input int prog);
    int          got;
    logic [15:0] prev;
    apb(1'b1, OFS_SMOOTH_CAL, w);
    rd_chk(OFS_SMOOTH_CAL, rb, 1'b0);
    repeat (2048) @(posedge pclk);
    @(negedge pclk);
    prev = cnt;
    got = 0;
    repeat (2048) begin
      @(negedge pclk);
      got += (prev >= cnt) ? prev - cnt : prev + DIV + 1 - cnt;
      chk("second_tick", 32'(tick), 32'(cnt > prev));
      prev = cnt;
    end
    chk("cal_progress", got, prog);
  endtask

  task automatic t_calib;
    cal_case(32'h00008000, 32'h00008000, 2560);
    cal_case(32'h000001FF, 32'h000001FF, 1537);
    cal_case(32'hFFFF41FF, 32'h000041FC, 1540);
    cal_case(32'h000021FF, 32'h000021FE, 1538);
    cal_case(32'h00006003, 32'h00004000, 2048);
    cal_case(32'h00000000, 32'h00000000, 2048);
    $display("test calib done");
  endtask

  task automatic pulse_update;
    @(posedge pclk);
    shadow_update <= 1'b1;
    @(posedge pclk);
    shadow_update <= 1'b0;
  endtask

  // Add-second never goes with a zero fraction
  task automatic shift_case(input logic [31:0] w);
    logic [15:0] c;
    logic [15:0] e;
    pulse_update;
    apb(1'b1, OFS_SHIFT_CTRL, w);
    @(negedge pclk);
    chk("pending", 32'(pend), 32'h00000001);
    chk("sync_clr", 32'(sync), 32'h00000000);
    c = cnt;
    @(negedge pclk);
    e = (c == 16'h0000) ? {1'b0, DIV} : c - 16'h0001;
    chk("count", 32'(cnt), 32'(e + {1'b0, w[14:0]}));
    chk("add_second", 32'(add_p), 32'(w[31]));
    pulse_update;
    @(negedge pclk);
    chk("sync_set", 32'(sync), 32'h00000001);
  endtask

  task automatic t_shift;
    shift_case(32'h80000100);
    shift_case(32'h00007000);
    rd_chk(OFS_SHIFT_CTRL, 32'h00000000, 1'b0);
    $display("test shift done");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    end_of_test;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    stamp_event = 1'b0;
    shadow_update = 1'b0;
    live_time = 32'h00000000;
    live_date = 32'h00000000;
    error_cnt = 0;
    checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_stamp;
    t_calib;
    t_shift;
    end_of_test;
  end
endmodule
`default_nettype wire
